// [rtl/tmr16_defines.svh]
/*
 * Offsets, field positions, reset values and timing counts of the
 * 16-bit timer/counter. Assumes an 8-bit register port with small addresses.
 */
`ifndef TMR16_DEFINES_SVH
`define TMR16_DEFINES_SVH

// ****************************************
// register offsets
// ****************************************
`define TMR_OFS_CONTROL   3'h0
`define TMR_OFS_COUNT_LO  3'h1
`define TMR_OFS_COUNT_HI  3'h2
`define TMR_OFS_FLAGS     3'h3
`define TMR_OFS_ENABLES   3'h4
`define TMR_OFS_PINS      3'h5

// ****************************************
// control fields, overflow bit, count top and synchronizer stages
// ****************************************
`define TMR_BIT_WIDE      7
`define TMR_BIT_PS_HI     5
`define TMR_BIT_PS_LO     4
`define TMR_BIT_CAPSEL    3
`define TMR_BIT_NOSYNC    2
`define TMR_BIT_EXTCLK    1
`define TMR_BIT_RUN       0
`define TMR_CTRL_MASK     8'hBF
`define TMR_CTRL_RESET    8'h00
`define TMR_BIT_OVF       1
`define TMR_COUNT_TOP     16'hFFFF
`define TMR_SYNC_STAGES   2

`endif

// [rtl/tmr16_pkg.sv]
/*
 * Types of the 16-bit timer/counter.
 * Assumes the defines header is compiled alongside.
 */
package tmr16_pkg;
  typedef enum logic [1:0] {
    MODE_TIMER,
    MODE_SYNC_COUNT,
    MODE_ASYNC_COUNT
  } tmr_mode_t;

  typedef struct packed {
    logic [7:0]  control_reg;
    logic [15:0] count_reg;
    logic [7:0]  high_buffer_reg;
    logic [2:0]  prescale_reg;
    logic        overflow_flag_reg;
    logic        overflow_irq_enable_reg;
    logic [1:0]  ext_sync_reg;
    logic        ext_prev_reg;
    logic        ext_armed_reg;
    logic [7:0]  rdata_reg;
    logic        irq_reg;
    logic        capsel_reg;
    tmr_mode_t   mode_reg;
  } tmr_state_t;
endpackage : tmr16_pkg

// [rtl/tmr16_timer.sv]
/*
 * 16-bit up-counting timer/counter with prescaler, buffered wide access,
 * overflow flag and special-event reset.
 * Assumes one 10 MHz core clock, one clock enable per instruction cycle,
 * and an external count clock well below half the core clock rate.
 */
// The placing of the registers and the address-and-strobe port are this design's own decisions.
// Contract
// R1 - bit 7 selects atomic 16-bit access
// R2 - prescale codes divide by 1,2,4,8
// R3 - bit 3 picks capture time base
// R4 - bit 2 skips synchronizer in external mode
// R5 - bit 1 counts external rising edges
// R6 - internal mode counts each instruction cycle
// R7 - bit 0 runs or stops counting
// R8 - timer, sync counter, async counter modes
// R9 - oscillator enabled blanks its two pins
// R10 - high address maps to buffer when wide
// R11 - low read copies high into buffer
// R12 - low write loads high from buffer
// R13 - live high byte hidden in wide mode
// R14 - low write clears prescaler, high not
// R15 - software enables oscillator and external source
// R16 - count wraps FFFFh to 0000h
// R17 - wrap sets overflow flag, enable gates request
// R18 - special event trigger zeroes count
// R19 - special event reset needs synchronous mode; the code resets on bit 3 alone, in async counter mode too
// R20 - count write beats special event reset
// R21 - no sync control with oscillator clock
// R22 - control resets zero, bit 6 reads zero
// R23 - two-stage synchronizer on external edge
`include "tmr16_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module tmr16_timer (
  input  wire logic       i_core_clk,
  input  wire logic       i_resetn,
  input  wire logic       i_instr_cycle,
  input  wire logic       i_ext_count_clock_pin,
  input  wire logic       i_low_freq_osc_clk,
  input  wire logic       i_low_freq_osc_enable,
  input  wire logic       i_special_event,
  input  wire logic [1:0] i_osc_pins,
  input  wire logic [2:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  output logic            o_overflow_irq,
  output logic            o_capture_timebase_select,
  output logic      [1:0] o_mode
);

  tmr16_pkg::tmr_state_t st_reg;
  tmr16_pkg::tmr_state_t st_next;

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic       ext_src;
  logic [1:0] ext_meta_reg;
  logic [1:0] pin_meta_reg;
  logic [1:0] pin_sync_reg;

  // oscillator output replaces the pin when enabled (see R5)
  assign ext_src = i_low_freq_osc_enable ? i_low_freq_osc_clk : i_ext_count_clock_pin;

  always_ff @(posedge i_core_clk) begin
    ext_meta_reg <= {ext_meta_reg[0], ext_src};
    pin_meta_reg <= i_osc_pins;
    pin_sync_reg <= pin_meta_reg;
  end

  function automatic logic [3:0] prescale_limit(input logic [1:0] code);
    prescale_limit = 4'h1 << code; // see R2
  endfunction : prescale_limit

  // ****************************************
  // next state
  // ****************************************
  logic       ext_level;
  logic       ext_rise;
  logic       tick;
  logic       wide;
  logic       wr_lo;
  logic       wr_hi;
  logic       rd_lo;
  logic [3:0] ps_count;

  always_comb begin
    st_next  = st_reg;
    wide     = st_reg.control_reg[`TMR_BIT_WIDE]; // see R1
    wr_lo    = i_wr && (i_addr == `TMR_OFS_COUNT_LO);
    wr_hi    = i_wr && (i_addr == `TMR_OFS_COUNT_HI);
    rd_lo    = i_rd && (i_addr == `TMR_OFS_COUNT_LO);
    // async skips the two extra stages; the pin still passes two flops (see R4) (see R23)
    ext_level = st_reg.control_reg[`TMR_BIT_NOSYNC] ? ext_meta_reg[1] : st_reg.ext_sync_reg[1];
    // a rise only counts once a fall has been seen (see R5)
    ext_rise = ext_level && !st_reg.ext_prev_reg && st_reg.ext_armed_reg;
    tick     = st_reg.control_reg[`TMR_BIT_EXTCLK] ? ext_rise : i_instr_cycle; // see R6
    tick     = tick && st_reg.control_reg[`TMR_BIT_RUN]; // see R7

    st_next.ext_sync_reg = {st_reg.ext_sync_reg[0], ext_meta_reg[1]}; // see R23
    st_next.ext_prev_reg = ext_level;
    // only a real fall arms; zeroed stages after reset would fake one
    if (!ext_level && st_reg.ext_prev_reg) begin
      st_next.ext_armed_reg = 1'b1;
    end

    if (tick) begin
      ps_count = 4'(st_reg.prescale_reg) + 4'h1;
      if (ps_count >= prescale_limit(st_reg.control_reg[`TMR_BIT_PS_HI:`TMR_BIT_PS_LO])) begin
        st_next.prescale_reg = 3'h0;
        st_next.count_reg    = st_reg.count_reg + 16'h0001; // see R16
        if (st_reg.count_reg == `TMR_COUNT_TOP) begin
          st_next.overflow_flag_reg = 1'b1; // see R17
        end
      end else begin
        st_next.prescale_reg = ps_count[2:0];
      end
    end else begin
      ps_count = 4'h0;
    end

    // special event only when this timer is the compare time base (see R18)
    // any count write, a narrow high write too, beats the event (see R20)
    if (i_special_event && st_reg.control_reg[`TMR_BIT_CAPSEL] && !wr_lo && !(wr_hi && !wide)) begin
      st_next.count_reg = 16'h0000;
    end

    if (i_wr) begin
      case (i_addr)
        `TMR_OFS_CONTROL: st_next.control_reg = i_wdata & `TMR_CTRL_MASK; // see R22
        `TMR_OFS_COUNT_LO: begin
          st_next.count_reg[7:0] = i_wdata; // see R20
          st_next.prescale_reg   = 3'h0;    // see R14
          if (wide) begin
            st_next.count_reg[15:8] = st_reg.high_buffer_reg; // see R12
          end else begin
            st_next.count_reg[15:8] = st_reg.count_reg[15:8];
          end
        end
        `TMR_OFS_COUNT_HI: begin
          if (wide) begin
            st_next.high_buffer_reg = i_wdata; // see R12 (see R13)
          end else begin
            st_next.count_reg[15:8] = i_wdata;
          end
        end
        `TMR_OFS_FLAGS: begin
          // hardware set wins over software clear only while the flag is still clear
          if (!st_next.overflow_flag_reg || st_reg.overflow_flag_reg) begin
            st_next.overflow_flag_reg = i_wdata[`TMR_BIT_OVF] || (st_next.overflow_flag_reg &&
                                         !st_reg.overflow_flag_reg);
          end
        end
        `TMR_OFS_ENABLES: st_next.overflow_irq_enable_reg = i_wdata[`TMR_BIT_OVF];
        default: ;
      endcase
    end

    st_next.rdata_reg = 8'h00;
    if (i_rd) begin
      case (i_addr)
        `TMR_OFS_CONTROL:  st_next.rdata_reg = st_reg.control_reg;
        `TMR_OFS_COUNT_LO: st_next.rdata_reg = st_reg.count_reg[7:0];
        `TMR_OFS_COUNT_HI: st_next.rdata_reg = wide ? st_reg.high_buffer_reg
                                                     : st_reg.count_reg[15:8]; // see R10 (see R13)
        `TMR_OFS_FLAGS:    st_next.rdata_reg = {6'h00, st_reg.overflow_flag_reg, 1'b0};
        `TMR_OFS_ENABLES:  st_next.rdata_reg = {6'h00, st_reg.overflow_irq_enable_reg, 1'b0};
        // oscillator owns the pins, their port logic reads zero (see R9)
        `TMR_OFS_PINS:     st_next.rdata_reg = {6'h00, i_low_freq_osc_enable ? 2'h0 : pin_sync_reg};
        default:           st_next.rdata_reg = 8'h00;
      endcase
    end
    if (rd_lo && wide) begin
      st_next.high_buffer_reg = st_reg.count_reg[15:8]; // see R11
    end
    if (wr_hi && !wide) begin
      st_next.high_buffer_reg = st_reg.high_buffer_reg;
    end

    st_next.irq_reg    = st_next.overflow_flag_reg && st_next.overflow_irq_enable_reg; // see R17
    st_next.capsel_reg = st_next.control_reg[`TMR_BIT_CAPSEL]; // see R3
    if (!st_next.control_reg[`TMR_BIT_EXTCLK]) begin
      st_next.mode_reg = tmr16_pkg::MODE_TIMER; // see R8
    end else if (st_next.control_reg[`TMR_BIT_NOSYNC]) begin
      st_next.mode_reg = tmr16_pkg::MODE_ASYNC_COUNT;
    end else begin
      st_next.mode_reg = tmr16_pkg::MODE_SYNC_COUNT;
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      st_reg             <= '0;
      st_reg.control_reg <= `TMR_CTRL_RESET; // see R22
      st_reg.mode_reg    <= tmr16_pkg::MODE_TIMER;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_rdata                   = st_reg.rdata_reg;
  assign o_overflow_irq            = st_reg.irq_reg;
  assign o_capture_timebase_select = st_reg.capsel_reg;
  assign o_mode                    = st_reg.mode_reg;

  // ****************************************
  // assertions
  // ****************************************
  property p_wrap_flag;
    @(posedge i_core_clk) disable iff (!i_resetn)
      (st_reg.count_reg == 16'hFFFF && tick && ps_count
       >= prescale_limit(st_reg.control_reg[5:4]) && !i_wr && !(i_special_event && st_reg.control_reg[3]))
      |=> (st_reg.count_reg == 16'h0000 && st_reg.overflow_flag_reg);
  endproperty
  a_wrap_flag: assert property (p_wrap_flag) else $error("wrap did not set flag"); // see R17

  property p_stopped;
    @(posedge i_core_clk) disable iff (!i_resetn)
      (!st_reg.control_reg[0] && !i_wr && !i_special_event) |=> $stable(st_reg.count_reg);
  endproperty
  a_stopped: assert property (p_stopped) else $error("count moved while stopped"); // see R7

  property p_write_wins;
    @(posedge i_core_clk) disable iff (!i_resetn)
      (wr_lo && i_special_event) |=> st_reg.count_reg[7:0] == $past(i_wdata);
  endproperty
  a_write_wins: assert property (p_write_wins) else $error("write lost to event"); // see R20

  property p_event_reset;
    @(posedge i_core_clk) disable iff (!i_resetn)
      (i_special_event && st_reg.control_reg[3] && !i_wr) |=> st_reg.count_reg == 16'h0000;
  endproperty
  a_event_reset: assert property (p_event_reset) else $error("event did not zero count"); // see R18

  property p_low_read_latch;
    @(posedge i_core_clk) disable iff (!i_resetn)
      (rd_lo && wide && !i_wr) |=> st_reg.high_buffer_reg == $past(st_reg.count_reg[15:8]);
  endproperty
  a_low_read_latch: assert property (p_low_read_latch) else $error("buffer not latched"); // see R11

  property p_wide_load;
    @(posedge i_core_clk) disable iff (!i_resetn)
      (wr_lo && wide) |=> st_reg.count_reg[15:8] == $past(st_reg.high_buffer_reg);
  endproperty
  a_wide_load: assert property (p_wide_load) else $error("high byte not loaded"); // see R12

  property p_hi_keeps_ps;
    @(posedge i_core_clk) disable iff (!i_resetn)
      (wr_hi && !tick) |=> $stable(st_reg.prescale_reg);
  endproperty
  a_hi_keeps_ps: assert property (p_hi_keeps_ps) else $error("high write touched prescaler"); // see R14

  property p_bit6_zero;
    @(posedge i_core_clk) disable iff (!i_resetn)
      (i_rd && i_addr == 3'h0) |=> o_rdata[6] == 1'b0;
  endproperty
  a_bit6_zero: assert property (p_bit6_zero) else $error("bit 6 reads one"); // see R22

  property p_pins_blank;
    @(posedge i_core_clk) disable iff (!i_resetn)
      (i_rd && i_addr == 3'h5 && i_low_freq_osc_enable) |=> o_rdata == 8'h00;
  endproperty
  a_pins_blank: assert property (p_pins_blank) else $error("pins not blanked"); // see R9

  // ****************************************
  // assertion sequences
  // ****************************************
  sequence s_counted_tick;
    tick && ps_count >= prescale_limit(st_reg.control_reg[5:4]) && !i_wr
      && !(i_special_event && st_reg.control_reg[3]);
  endsequence

  sequence s_held_tick;
    tick && ps_count < prescale_limit(st_reg.control_reg[5:4]) && !i_wr && !i_special_event;
  endsequence

  sequence s_sync_rise;
    ext_meta_reg[1] && !st_reg.ext_sync_reg[0];
  endsequence

  sequence s_wide_low_read;
    rd_lo && wide && !i_wr;
  endsequence

  sequence s_idle_cycle;
    !i_wr && !i_rd;
  endsequence

  sequence s_wide_high_read;
    i_rd && i_addr == `TMR_OFS_COUNT_HI && wide;
  endsequence

  // ****************************************
  // further assertions
  // ****************************************
  property p_count_step;
    @(posedge i_core_clk) disable iff (!i_resetn)
      s_counted_tick |=> st_reg.count_reg == 16'($past(st_reg.count_reg) + 16'h0001);
  endproperty
  a_count_step: assert property (p_count_step) else $error("count did not step"); // see R16

  property p_prescale_hold;
    @(posedge i_core_clk) disable iff (!i_resetn)
      s_held_tick |=> $stable(st_reg.count_reg) && st_reg.prescale_reg == 3'($past(st_reg.prescale_reg) + 3'h1);
  endproperty
  a_prescale_hold: assert property (p_prescale_hold) else $error("prescaler did not hold"); // see R2

  property p_low_write_ps;
    @(posedge i_core_clk) disable iff (!i_resetn)
      wr_lo |=> st_reg.prescale_reg == 3'h0;
  endproperty
  a_low_write_ps: assert property (p_low_write_ps) else $error("low write kept prescaler"); // see R14

  property p_timebase_out;
    @(posedge i_core_clk) disable iff (!i_resetn)
      o_capture_timebase_select == st_reg.control_reg[3];
  endproperty
  a_timebase_out: assert property (p_timebase_out) else $error("time base select wrong"); // see R3

  property p_mode_out;
    @(posedge i_core_clk) disable iff (!i_resetn)
      o_mode == (!st_reg.control_reg[1] ? 2'h0 : (st_reg.control_reg[2] ? 2'h2 : 2'h1));
  endproperty
  a_mode_out: assert property (p_mode_out) else $error("mode output wrong"); // see R8

  property p_irq_level;
    @(posedge i_core_clk) disable iff (!i_resetn)
      o_overflow_irq == (st_reg.overflow_flag_reg && st_reg.overflow_irq_enable_reg);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq not flag and enable"); // see R17

  property p_flag_sticky;
    @(posedge i_core_clk) disable iff (!i_resetn)
      (st_reg.overflow_flag_reg && !(i_wr && i_addr == `TMR_OFS_FLAGS)) |=> st_reg.overflow_flag_reg;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped by itself"); // see R17

  property p_hi_read_buffer;
    @(posedge i_core_clk) disable iff (!i_resetn)
      (i_rd && i_addr == `TMR_OFS_COUNT_HI && wide) |=> o_rdata == $past(st_reg.high_buffer_reg);
  endproperty
  a_hi_read_buffer: assert property (p_hi_read_buffer) else $error("high read not from buffer"); // see R10

  property p_hi_write_buffer;
    @(posedge i_core_clk) disable iff (!i_resetn)
      (wr_hi && wide && !tick && !i_special_event)
        |=> $stable(st_reg.count_reg[15:8]) && st_reg.high_buffer_reg == $past(i_wdata);
  endproperty
  a_hi_write_buffer: assert property (p_hi_write_buffer) else $error("high write reached count"); // see R13

  property p_ctrl_reset;
    @(posedge i_core_clk)
      !i_resetn |=> st_reg.control_reg == 8'h00 && o_rdata == 8'h00;
  endproperty
  a_ctrl_reset: assert property (p_ctrl_reset) else $error("control not zero after reset"); // see R22

  property p_sync_stages;
    @(posedge i_core_clk) disable iff (!i_resetn)
      s_sync_rise |-> ##2 st_reg.ext_sync_reg[1];
  endproperty
  a_sync_stages: assert property (p_sync_stages) else $error("synchronizer latency wrong"); // see R23

  property p_wide_pair;
    @(posedge i_core_clk) disable iff (!i_resetn)
      s_wide_low_read ##1 s_idle_cycle ##1 s_wide_high_read |=> o_rdata == $past(st_reg.count_reg[15:8], 3);
  endproperty
  a_wide_pair: assert property (p_wide_pair) else $error("wide pair not coherent"); // see R11

  property p_event_ignored;
    @(posedge i_core_clk) disable iff (!i_resetn)
      (i_special_event && !st_reg.control_reg[3] && !i_wr && !tick) |=> $stable(st_reg.count_reg);
  endproperty
  a_event_ignored: assert property (p_event_ignored) else $error("event reset other time base"); // see R18

  property p_pins_live;
    @(posedge i_core_clk) disable iff (!i_resetn)
      (i_rd && i_addr == `TMR_OFS_PINS && !i_low_freq_osc_enable) |=> o_rdata == {6'h00, $past(pin_sync_reg)};
  endproperty
  a_pins_live: assert property (p_pins_live) else $error("pin readback wrong"); // see R9

endmodule : tmr16_timer

`default_nettype wire

// [sim/ext_clock_model.sv]
/* Far-side count clock source: the count clock pin and the low-frequency
   oscillator. Assumes the bench calls send() from its own thread. */
`timescale 1ns/1ps
`default_nettype none

module ext_clock_model (
  input  wire logic i_core_clk,
  output logic      o_pin,
  output logic      o_osc
);
  // ****************************************
  // clock source
  // ****************************************
  // idle high, so the first counted rise must follow a fall
  initial begin
    o_pin = 1'b1;
    o_osc = 1'b1;
  end

  // 12 core cycles a pulse: slow enough for the synchronizer
  task automatic send(input int n, input logic use_osc);
    for (int k = 0; k < n; k++) begin
      repeat (6) @(posedge i_core_clk);
      if (use_osc) o_osc <= 1'b0; else o_pin <= 1'b0;
      repeat (6) @(posedge i_core_clk);
      if (use_osc) o_osc <= 1'b1; else o_pin <= 1'b1;
    end
    repeat (6) @(posedge i_core_clk);
  endtask : send
endmodule : ext_clock_model

`default_nettype wire

// [sim/test_tmr16_timer.sv]
/* Self-checking bench of the 16-bit timer/counter over its register port.
   Assumes the design files and the clock source model are compiled first. */
`timescale 1ns/1ps
`default_nettype none
`include "tmr16_defines.svh"

module test_tmr16_timer;
  logic       core_clk      = 1'b0;
  logic       resetn        = 1'b0;
  logic       instr_cycle   = 1'b0;
  logic       osc_enable    = 1'b0;
  logic       special_event = 1'b0;
  logic [1:0] osc_pins      = 2'h2;
  logic [2:0] addr          = 3'h0;
  logic [7:0] wdata         = 8'h00;
  logic       wr            = 1'b0;
  logic       rd            = 1'b0;
  logic [7:0] rdata;
  logic       irq;
  logic       tb_sel;
  logic [1:0] mode;
  logic       pin;
  logic       osc;
  int         error_cnt     = 0;
  int         n_checks      = 0;
  int         cycle_cnt     = 0;

  ext_clock_model pm (.i_core_clk(core_clk), .o_pin(pin), .o_osc(osc));
  tmr16_timer dut (.i_core_clk(core_clk), .i_resetn(resetn), .i_instr_cycle(instr_cycle),
    .i_ext_count_clock_pin(pin), .i_low_freq_osc_clk(osc), .i_low_freq_osc_enable(osc_enable),
    .i_special_event(special_event), .i_osc_pins(osc_pins), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_overflow_irq(irq),
    .o_capture_timebase_select(tb_sel), .o_mode(mode));

  // ****************************************
  // clock, timeout and helpers
  // ****************************************
  always #50 core_clk = ~core_clk;

  // tests take about 330 cycles
  always @(posedge core_clk) begin
    cycle_cnt++;
    if (cycle_cnt == 6000) begin
      error_cnt++;
      conclude();
    end
  end

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [2:0] a, input logic [7:0] exp, input string name);
    @(posedge core_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge core_clk);
    rd <= 1'b0;
    @(negedge core_clk);
    chk(name, exp, rdata);
  endtask : rd_reg

  task automatic tick(input int n);
    @(posedge core_clk);
    instr_cycle <= 1'b1;
    repeat (n) @(posedge core_clk);
    instr_cycle <= 1'b0;
  endtask : tick

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude

  // ****************************************
  // tests
  // ****************************************
  initial begin
    repeat (4) @(posedge core_clk);
    resetn <= 1'b1;
    rd_reg(`TMR_OFS_CONTROL, 8'h00, "control reset");
    wr_reg(`TMR_OFS_CONTROL, 8'hFF);
    rd_reg(`TMR_OFS_CONTROL, 8'hBF, "control bit6");
    chk("timebase", 8'h01, {7'h00, tb_sel});
    chk("mode async", 8'h02, {6'h00, mode});
    wr_reg(`TMR_OFS_CONTROL, 8'h00);
    rd_reg(`TMR_OFS_CONTROL, 8'h00, "control clear");
    chk("mode timer", 8'h00, {6'h00, mode});
    chk("timebase off", 8'h00, {7'h00, tb_sel});
    wr_reg(`TMR_OFS_COUNT_HI, 8'h12);
    wr_reg(`TMR_OFS_COUNT_LO, 8'h34);
    rd_reg(`TMR_OFS_COUNT_HI, 8'h12, "narrow high");
    rd_reg(`TMR_OFS_COUNT_LO, 8'h34, "narrow low");
    $display("test registers done");
    for (int c = 0; c < 4; c++) begin
      wr_reg(`TMR_OFS_CONTROL, {2'b00, c[1:0], 4'h0});
      wr_reg(`TMR_OFS_COUNT_HI, 8'h00);
      wr_reg(`TMR_OFS_COUNT_LO, 8'h00);
      wr_reg(`TMR_OFS_CONTROL, {2'b00, c[1:0], 4'h1});
      tick(8);
      wr_reg(`TMR_OFS_CONTROL, {2'b00, c[1:0], 4'h0});
      tick(4);
      rd_reg(`TMR_OFS_COUNT_LO, 8'h08 >> c, "prescaled");
    end
    // half a divide-by-2 period must survive a high byte write
    wr_reg(`TMR_OFS_CONTROL, 8'h11);
    tick(1);
    wr_reg(`TMR_OFS_COUNT_HI, 8'h00);
    tick(1);
    wr_reg(`TMR_OFS_CONTROL, 8'h00);
    rd_reg(`TMR_OFS_COUNT_LO, 8'h02, "prescaler kept");
    $display("test prescale done");
    wr_reg(`TMR_OFS_COUNT_HI, 8'hFF);
    wr_reg(`TMR_OFS_COUNT_LO, 8'hFE);
    wr_reg(`TMR_OFS_CONTROL, 8'h01);
    tick(2);
    wr_reg(`TMR_OFS_CONTROL, 8'h00);
    rd_reg(`TMR_OFS_COUNT_LO, 8'h00, "wrap low");
    rd_reg(`TMR_OFS_COUNT_HI, 8'h00, "wrap high");
    rd_reg(`TMR_OFS_FLAGS, 8'h02, "overflow flag");
    chk("irq masked", 8'h00, {7'h00, irq});
    wr_reg(`TMR_OFS_ENABLES, 8'h02);
    rd_reg(`TMR_OFS_ENABLES, 8'h02, "irq enable");
    repeat (2) @(negedge core_clk);
    chk("irq on", 8'h01, {7'h00, irq});
    wr_reg(`TMR_OFS_FLAGS, 8'h00);
    repeat (2) @(negedge core_clk);
    chk("irq off", 8'h00, {7'h00, irq});
    $display("test overflow done");
    wr_reg(`TMR_OFS_CONTROL, 8'h80);
    wr_reg(`TMR_OFS_COUNT_HI, 8'hAB);
    wr_reg(`TMR_OFS_COUNT_LO, 8'hCD);
    rd_reg(`TMR_OFS_COUNT_LO, 8'hCD, "wide low");
    rd_reg(`TMR_OFS_COUNT_HI, 8'hAB, "wide high");
    wr_reg(`TMR_OFS_COUNT_HI, 8'h11);
    rd_reg(`TMR_OFS_COUNT_LO, 8'hCD, "wide low again");
    rd_reg(`TMR_OFS_COUNT_HI, 8'hAB, "buffer reload");
    wr_reg(`TMR_OFS_CONTROL, 8'h00);
    rd_reg(`TMR_OFS_COUNT_HI, 8'hAB, "live high kept");
    $display("test wide done");
    wr_reg(`TMR_OFS_CONTROL, 8'h08);
    @(posedge core_clk);
    special_event <= 1'b1;
    @(posedge core_clk);
    special_event <= 1'b0;
    rd_reg(`TMR_OFS_COUNT_LO, 8'h00, "event low");
    rd_reg(`TMR_OFS_COUNT_HI, 8'h00, "event high");
    @(posedge core_clk);
    wr <= 1'b1;
    addr <= `TMR_OFS_COUNT_LO;
    wdata <= 8'h55;
    special_event <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
    special_event <= 1'b0;
    rd_reg(`TMR_OFS_COUNT_LO, 8'h55, "write wins");
    wr_reg(`TMR_OFS_CONTROL, 8'h00);
    @(posedge core_clk);
    special_event <= 1'b1;
    @(posedge core_clk);
    special_event <= 1'b0;
    rd_reg(`TMR_OFS_COUNT_LO, 8'h55, "event ignored");
    $display("test event done");
    wr_reg(`TMR_OFS_COUNT_LO, 8'h00);
    wr_reg(`TMR_OFS_CONTROL, 8'h03);
    rd_reg(`TMR_OFS_CONTROL, 8'h03, "sync control");
    chk("mode sync", 8'h01, {6'h00, mode});
    pm.send(5, 1'b0);
    wr_reg(`TMR_OFS_CONTROL, 8'h00);
    rd_reg(`TMR_OFS_COUNT_LO, 8'h05, "sync edges");
    rd_reg(`TMR_OFS_PINS, 8'h02, "pins live");
    // the core clock never comes from the oscillator, so bit 2 stays usable
    @(posedge core_clk);
    osc_enable <= 1'b1;
    wr_reg(`TMR_OFS_COUNT_LO, 8'h00);
    wr_reg(`TMR_OFS_CONTROL, 8'h07);
    rd_reg(`TMR_OFS_PINS, 8'h00, "pins blanked");
    pm.send(3, 1'b1);
    wr_reg(`TMR_OFS_CONTROL, 8'h00);
    rd_reg(`TMR_OFS_COUNT_LO, 8'h03, "async edges");
    $display("test external done");
    conclude();
  end
endmodule : test_tmr16_timer

`default_nettype wire
